// ===== pkg/sltdc_pkg.sv
/*
 * Constants shared by the sink link training and deep colour pacing block:
 * register offsets, field positions, reset values, pattern codes and counts.
 * Assumes a single 20 MHz system clock samples every link-side signal.
 */
package sltdc_pkg;

   // Register byte offsets on the plain register port.
   localparam logic [7:0]  ADDR_CTRL       = 8'h00;
   localparam logic [7:0]  ADDR_STATUS     = 8'h04;
   localparam logic [7:0]  ADDR_PATTERN    = 8'h08;

   // Control register fields.
   localparam int          CTRL_FRL_BIT    = 0;
   localparam int          CTRL_DEPTH_LSB  = 1;
   localparam int          CTRL_RETRAIN_BIT = 3;
   localparam logic [2:0]  CTRL_RESET_VAL  = 3'h0;

   // Colour depth encodings held in the control register.
   localparam logic [1:0]  DEPTH_8         = 2'h0;
   localparam logic [1:0]  DEPTH_10        = 2'h1;
   localparam logic [1:0]  DEPTH_12        = 2'h2;
   localparam logic [1:0]  DEPTH_16        = 2'h3;

   // Pacing cadence: valid beats out of cadence length per depth.
   localparam logic [2:0]  CAD_LEN_8       = 3'h1;
   localparam logic [2:0]  CAD_NUM_8       = 3'h1;
   localparam logic [2:0]  CAD_LEN_10      = 3'h5;
   localparam logic [2:0]  CAD_NUM_10      = 3'h4;
   localparam logic [2:0]  CAD_LEN_12      = 3'h3;
   localparam logic [2:0]  CAD_NUM_12      = 3'h2;
   localparam logic [2:0]  CAD_LEN_16      = 3'h2;
   localparam logic [2:0]  CAD_NUM_16      = 3'h1;

   // Training pattern codes sent back to the source.
   localparam logic [15:0] PATTERN_REQUEST = 16'h5678;
   localparam logic [15:0] PATTERN_PASSED  = 16'h0000;

   // Training sequence lengths and the restart character value.
   localparam int          SR_CHARS        = 4;
   localparam int          DATA_CHARS      = 4096;
   localparam logic [9:0]  SR_SYMBOL_VAL   = 10'h155;

   // Lane counts per operating mode.
   localparam int          LANES_TMDS      = 3;
   localparam int          LANES_FRL       = 4;

   typedef enum logic [1:0] {
      TRN_REQUEST,
      TRN_LOCK,
      TRN_QUALIFY,
      TRN_PASSED
   } sltdc_trn_t;

endpackage

// ===== core/sltdc_sink.sv
/*
 * Sink link training and deep colour pacing: lane capture, decode strobe,
 * training state machine and pixel valid pacing onto the video clock.
 * Assumes every link-side clock and level is a pin sampled by CLOCK, and
 * that the link clocks run well below half the CLOCK rate.
 */
`timescale 1ns/1ps
module sltdc_sink
   import sltdc_pkg::*;
#(
   parameter int         SYM_W      = 10,
   parameter int         SR_NUM     = SR_CHARS,
   parameter int         DATA_NUM   = DATA_CHARS,
   parameter logic [9:0] SR_SYMBOL  = SR_SYMBOL_VAL
) (
   input  wire logic                  CLOCK,
   input  wire logic                  RESET,
   input  wire logic                  CLOCK_EN,
   input  wire logic [7:0]            ADDRESS,
   input  wire logic [31:0]           WRITE_DATA,
   input  wire logic                  WRITE_STROBE,
   input  wire logic                  READ_STROBE,
   output logic      [31:0]           READ_DATA,
   input  wire logic [2:0]            RECOVERED_CLK,
   input  wire logic                  LINK_SPEED_CLK,
   input  wire logic                  VIDEO_CLK,
   input  wire logic [4*SYM_W-1:0]    LANE_DATA,
   input  wire logic [3:0]            ALIGN_LOCK,
   input  wire logic [3:0]            DESKEW_LOCK,
   output logic                       CDR_REF_SEL,
   output logic      [15:0]           PATTERN_CODE,
   output logic                       TRAIN_PASSED,
   output logic      [3*SYM_W-1:0]    PIX_DATA,
   output logic                       PIX_VALID
);

   localparam int LANES = LANES_FRL;

   logic [12:0]      ctl_s1_reg, ctl_s2_reg, ctl_s3_reg;
   logic [SYM_W-1:0] lane_s1_reg [LANES];
   logic [SYM_W-1:0] lane_s2_reg [LANES];
   logic [SYM_W-1:0] lane_sym_reg [LANES];
   logic [2:0]       recov_edge;
   logic             ls_edge, vid_edge, dec_stb;
   logic [3:0]       lane_stb, lane_mask, lane_lock, sr_hit;
   logic             all_locked, sr_all;
   logic             frl_reg;
   logic [1:0]       depth_reg;
   logic             retrain;
   sltdc_trn_t       trn_reg, trn_next;
   logic [2:0]       sr_cnt_reg;
   logic [12:0]      data_cnt_reg;
   logic [3*SYM_W-1:0] pix_hold_reg;
   logic             pending_reg, consume, allowed;
   logic [2:0]       cad_reg, cad_len, cad_num;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection.

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         ctl_s1_reg <= 13'h0000;
         ctl_s2_reg <= 13'h0000;
         ctl_s3_reg <= 13'h0000;
      end else if (CLOCK_EN) begin
         ctl_s1_reg <= {DESKEW_LOCK, ALIGN_LOCK, VIDEO_CLK, LINK_SPEED_CLK, RECOVERED_CLK};
         ctl_s2_reg <= ctl_s1_reg;
         ctl_s3_reg <= ctl_s2_reg;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         for (int i = 0; i < LANES; i++) begin
            lane_s1_reg[i] <= '0;
            lane_s2_reg[i] <= '0;
         end
      end else if (CLOCK_EN) begin
         for (int i = 0; i < LANES; i++) begin
            lane_s1_reg[i] <= LANE_DATA[i*SYM_W +: SYM_W];
            lane_s2_reg[i] <= lane_s1_reg[i];
         end
      end
   end

   assign recov_edge = ctl_s2_reg[2:0] & ~ctl_s3_reg[2:0];
   assign ls_edge    = ctl_s2_reg[3] & ~ctl_s3_reg[3];
   assign vid_edge   = ctl_s2_reg[4] & ~ctl_s3_reg[4];
   assign lane_lock  = ctl_s2_reg[8:5] & ctl_s2_reg[12:9];

   ////////////////////////////////////////////////////////////////////////////
   // Register port.

   assign retrain = WRITE_STROBE && ADDRESS == ADDR_CTRL && WRITE_DATA[CTRL_RETRAIN_BIT];

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         frl_reg     <= CTRL_RESET_VAL[CTRL_FRL_BIT];
         depth_reg   <= CTRL_RESET_VAL[CTRL_DEPTH_LSB +: 2];
         CDR_REF_SEL <= CTRL_RESET_VAL[CTRL_FRL_BIT];
      end else if (CLOCK_EN && WRITE_STROBE && ADDRESS == ADDR_CTRL) begin
         frl_reg     <= WRITE_DATA[CTRL_FRL_BIT];
         depth_reg   <= WRITE_DATA[CTRL_DEPTH_LSB +: 2];
         CDR_REF_SEL <= WRITE_DATA[CTRL_FRL_BIT];
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         READ_DATA <= 32'h00000000;
      end else if (CLOCK_EN) begin
         READ_DATA <= 32'h00000000;
         if (READ_STROBE) begin
            case (ADDRESS)
               ADDR_CTRL:    READ_DATA <= {29'h0, depth_reg, frl_reg};
               ADDR_STATUS:  READ_DATA <= {24'h0, lane_lock, all_locked,
                                           trn_reg == TRN_QUALIFY, trn_reg == TRN_LOCK,
                                           TRAIN_PASSED};
               ADDR_PATTERN: READ_DATA <= {16'h0, PATTERN_CODE};
               default:      READ_DATA <= 32'h00000000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lane capture and decode strobe.

   assign lane_mask = frl_reg ? 4'hF : 4'h7;

   always_comb begin
      for (int i = 0; i < LANES; i++) begin
         if (frl_reg) begin
            lane_stb[i] = (i < LANES_TMDS) ? recov_edge[i] : recov_edge[0];
         end else begin
            lane_stb[i] = ls_edge;
         end
         sr_hit[i] = (lane_sym_reg[i] == SR_SYMBOL[SYM_W-1:0]) || !lane_mask[i];
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         for (int i = 0; i < LANES; i++) begin
            lane_sym_reg[i] <= '0;
         end
      end else if (CLOCK_EN) begin
         for (int i = 0; i < LANES; i++) begin
            if (lane_stb[i]) begin
               lane_sym_reg[i] <= lane_s2_reg[i];
            end
         end
      end
   end

   assign dec_stb    = frl_reg ? recov_edge[0] : ls_edge;
   assign all_locked = &(lane_lock | ~lane_mask);
   assign sr_all     = &sr_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Training state machine.

   always_comb begin
      trn_next = trn_reg;
      case (trn_reg)
         TRN_REQUEST: begin
            if (dec_stb && sr_all && sr_cnt_reg == 3'(SR_NUM - 1)) begin
               trn_next = TRN_LOCK;
            end
         end
         TRN_LOCK:    if (all_locked) trn_next = TRN_QUALIFY;
         TRN_QUALIFY: begin
            if (!all_locked) begin
               trn_next = TRN_REQUEST;
            end else if (dec_stb && data_cnt_reg == 13'(DATA_NUM - 1)) begin
               trn_next = TRN_PASSED;
            end
         end
         TRN_PASSED:  trn_next = TRN_PASSED;
         default:     trn_next = TRN_REQUEST;
      endcase
      if (retrain) begin
         trn_next = TRN_REQUEST;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         trn_reg      <= TRN_REQUEST;
         sr_cnt_reg   <= 3'h0;
         data_cnt_reg <= 13'h0000;
      end else if (CLOCK_EN) begin
         trn_reg <= trn_next;
         if (trn_reg != TRN_REQUEST || (dec_stb && !sr_all)) begin
            sr_cnt_reg <= 3'h0;
         end else if (dec_stb) begin
            sr_cnt_reg <= sr_cnt_reg + 3'h1;
         end
         // Count data characters of the pattern.
         if (trn_reg != TRN_QUALIFY) begin
            data_cnt_reg <= 13'h0000;
         end else if (dec_stb) begin
            data_cnt_reg <= data_cnt_reg + 13'h0001;
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         PATTERN_CODE <= PATTERN_REQUEST;
         TRAIN_PASSED <= 1'b0;
      end else if (CLOCK_EN) begin
         PATTERN_CODE <= (trn_reg == TRN_PASSED) ? PATTERN_PASSED : PATTERN_REQUEST;
         TRAIN_PASSED <= trn_reg == TRN_PASSED;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pixel resampling and valid pacing.

   always_comb begin
      case (depth_reg)
         DEPTH_10: begin cad_len = CAD_LEN_10; cad_num = CAD_NUM_10; end
         DEPTH_12: begin cad_len = CAD_LEN_12; cad_num = CAD_NUM_12; end
         DEPTH_16: begin cad_len = CAD_LEN_16; cad_num = CAD_NUM_16; end
         default:  begin cad_len = CAD_LEN_8;  cad_num = CAD_NUM_8;  end
      endcase
   end

   assign allowed = !frl_reg || cad_reg < cad_num;
   assign consume = vid_edge && pending_reg && allowed;

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         cad_reg      <= 3'h0;
         pending_reg  <= 1'b0;
         pix_hold_reg <= '0;
      end else if (CLOCK_EN) begin
         // In FRL mode an idle beat restarts the cadence, so the next word to wait is taken on the following beat.
         if (vid_edge && frl_reg && !pending_reg) begin
            cad_reg <= 3'h0;
         end else if (vid_edge) begin
            cad_reg <= (cad_reg >= cad_len - 3'h1) ? 3'h0 : cad_reg + 3'h1;
         end
         if (dec_stb) begin
            pix_hold_reg <= {lane_s2_reg[2], lane_s2_reg[1], lane_s2_reg[0]};
         end
         // A new word wins over the consume in the same cycle.
         pending_reg <= dec_stb || (pending_reg && !consume);
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         PIX_VALID <= 1'b0;
         PIX_DATA  <= '0;
      end else if (CLOCK_EN && vid_edge) begin
         PIX_VALID <= pending_reg && allowed;
         if (consume) begin
            PIX_DATA <= pix_hold_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);

   a_pattern_request: assert property (CLOCK_EN && trn_reg != TRN_PASSED |=>
      PATTERN_CODE == PATTERN_REQUEST) else $error("Pattern request code wrong.");
   a_pattern_passed: assert property (CLOCK_EN && trn_reg == TRN_PASSED |=>
      PATTERN_CODE == PATTERN_PASSED && TRAIN_PASSED) else $error("Pass code missing.");
   a_lock_before_qualify: assert property ($rose(trn_reg == TRN_QUALIFY) |->
      $past(all_locked)) else $error("Qualified without lock.");
   a_lock_loss_return: assert property (CLOCK_EN && !retrain && trn_reg == TRN_QUALIFY
      && !all_locked |=> trn_reg == TRN_REQUEST) else $error("Lock loss not handled.");
   a_cdr_ref_mode: assert property (CLOCK_EN && WRITE_STROBE && ADDRESS == ADDR_CTRL
      |=> CDR_REF_SEL == $past(WRITE_DATA[CTRL_FRL_BIT])) else $error("CDR select wrong.");
   a_lane_own_clock: assert property (CLOCK_EN && frl_reg && recov_edge[1] |=>
      lane_sym_reg[1] == $past(lane_s2_reg[1])) else $error("Lane one not captured.");
   a_common_clock: assert property (CLOCK_EN && !frl_reg && !ls_edge |=>
      $stable(lane_sym_reg[0]) && $stable(lane_sym_reg[2])) else $error("Lane moved.");
   a_tmds_valid: assert property (CLOCK_EN && vid_edge && !frl_reg && pending_reg
      |=> PIX_VALID) else $error("TMDS valid dropped.");
   a_frl_cadence: assert property (CLOCK_EN && vid_edge && frl_reg && !allowed |=>
      !PIX_VALID) else $error("Valid outside cadence.");
   a_valid_real: assert property (CLOCK_EN && vid_edge && !pending_reg |=>
      !PIX_VALID) else $error("Valid without pixel.");
   a_frl_resample: assert property (CLOCK_EN && consume && frl_reg |=>
      PIX_VALID && PIX_DATA == $past(pix_hold_reg)) else $error("Pixel not presented.");

   c_train_passed: cover property (trn_reg == TRN_QUALIFY ##1 trn_reg == TRN_PASSED);
   c_lock_lost:    cover property (trn_reg == TRN_QUALIFY ##1 trn_reg == TRN_REQUEST);
   c_frl_valid:    cover property (frl_reg && PIX_VALID && depth_reg == DEPTH_10);
   c_tmds_valid:   cover property (!frl_reg && PIX_VALID);

endmodule // sltdc_sink

// ===== verif/sltdc_src_model.sv
/*
 * Behavioural upstream source for the sink training and pacing block:
 * link clock, recovered clocks for lanes 0 to 2, lane symbols and lane lock levels.
 * Assumes the bench starts frames with frame_on and requests restart
 * characters through send_restart.
 */
`timescale 1ns/1ps
module sltdc_src_model
   import sltdc_pkg::*;
#(
   parameter realtime HALF = 200.0
) (
   input  wire logic        frame_on,
   input  wire logic [3:0]  lock_mask,
   output logic             link_clk,
   output logic [2:0]       rec_clk,
   output logic [39:0]      lane_data,
   output logic [3:0]       align_lock,
   output logic [3:0]       deskew_lock
);
   logic [7:0] cnt;
   int         sr_left;

   task automatic send_restart(input int n);
      sr_left = n;
   endtask

   assign align_lock  = lock_mask;
   assign deskew_lock = lock_mask;

   initial begin
      link_clk  = 1'b0;
      rec_clk   = 3'h0;
      lane_data = 40'h0;
      cnt       = 8'h00;
      sr_left   = 0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Clocks stand still outside frames; idle lanes toggle so no stale value shows.
   // Restart characters, then data.
   // Lane clocks stand in for FRL source.
   always begin
      #(HALF);
      if (frame_on) begin
         link_clk = 1'b1;
         rec_clk[0] = 1'b1;
         rec_clk[1] <= #20 1'b1;
         rec_clk[2] <= #40 1'b1;
      end
      #(HALF);
      link_clk = 1'b0;
      rec_clk[0] = 1'b0;
      rec_clk[1] <= #20 1'b0;
      rec_clk[2] <= #40 1'b0;
      if (frame_on) begin
         for (int i = 0; i < 4; i++)
            lane_data[i*10 +: 10] = (sr_left > 0) ? SR_SYMBOL_VAL : 10'(cnt) + 10'(i);
         if (sr_left > 0)
            sr_left--;
         else
            cnt++;
      end else
         lane_data = ~lane_data;
   end
endmodule // sltdc_src_model

// ===== verif/tb_top.sv
/*
 * Self-checking bench for the sink training and pacing block: reset values,
 * register port, training sequence and pixel valid pacing.
 * Assumes the source model drives the link pins and DATA_NUM is set to 8.
 */
`timescale 1ns/1ps
module tb_top
   import sltdc_pkg::*;
;
   localparam int TMO = 20000;
   logic        clock = 1'b0, reset = 1'b1, video_clk = 1'b0, frame_on = 1'b0;
   logic        wr = 1'b0, rd = 1'b0, en = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  lock_mask = 4'h0, align, deskew;
   logic [2:0]  rclk;
   logic        lclk, cdr_sel, passed, pvalid;
   logic [39:0] lanes;
   logic [15:0] pcode;
   logic [29:0] pdata;
   realtime     vid_half = 250.0;
   int          miscompares = 0, cmp_count = 0, cyc = 0, beats, nvalid, run, max_run;
   bit          mon_on = 1'b0;

   sltdc_sink #(.DATA_NUM(8)) sltdc_sink_i (
      .CLOCK(clock), .RESET(reset), .CLOCK_EN(en), .ADDRESS(addr),
      .WRITE_DATA(wdata), .WRITE_STROBE(wr), .READ_STROBE(rd), .READ_DATA(rdata),
      .RECOVERED_CLK(rclk), .LINK_SPEED_CLK(lclk), .VIDEO_CLK(video_clk),
      .LANE_DATA(lanes), .ALIGN_LOCK(align), .DESKEW_LOCK(deskew),
      .CDR_REF_SEL(cdr_sel), .PATTERN_CODE(pcode), .TRAIN_PASSED(passed),
      .PIX_DATA(pdata), .PIX_VALID(pvalid));

   sltdc_src_model src_i (
      .frame_on(frame_on), .lock_mask(lock_mask), .link_clk(lclk), .rec_clk(rclk),
      .lane_data(lanes), .align_lock(align), .deskew_lock(deskew));

   always #25 clock = ~clock;
   always #(vid_half) video_clk = ~video_clk;

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == TMO) begin
         miscompares++;
         end_of_test();
      end
   end

   // Each video edge judges the settled valid flag of the previous beat.
   // Words taken only on valid.
   always @(posedge video_clk) begin
      if (mon_on) begin
         beats++;
         if (pvalid === 1'b1) begin
            nvalid++;
            run++;
            if (run > max_run)
               max_run = run;
            chk("PIX_DATA lane1", 32'(pdata[9:0] + 10'h1), 32'(pdata[19:10]));
            chk("PIX_DATA lane2", 32'(pdata[9:0] + 10'h2), 32'(pdata[29:20]));
         end else
            run = 0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1 chk(what, exp, rdata);
   endtask

   task automatic set_lock(input logic [3:0] m, input int words);
      @(posedge clock);
      lock_mask <= m;
      repeat (words * 8) @(posedge clock);
   endtask

   task automatic t_reset();
      chk("PATTERN_CODE", 32'(PATTERN_REQUEST), 32'(pcode));
      chk("TRAIN_PASSED", 32'h0, 32'(passed));
      chk("CDR_REF_SEL", 32'h0, 32'(cdr_sel));
      chk("PIX_VALID", 32'h0, 32'(pvalid));
      reg_rd(ADDR_CTRL, 32'h0, "CTRL reset");
      reg_rd(ADDR_PATTERN, 32'(PATTERN_REQUEST), "PATTERN reg");
      reg_wr(8'h0C, 32'hFFFFFFFF);
      reg_rd(8'h0C, 32'h0, "unmapped read");
      reg_rd(ADDR_CTRL, 32'h0, "CTRL after unmapped write");
      @(posedge clock);
      en <= 1'b0;
      reg_wr(ADDR_CTRL, 32'h1);
      en <= 1'b1;
      #1 chk("CDR_REF_SEL frozen", 32'h0, 32'(cdr_sel));
      reg_rd(ADDR_CTRL, 32'h0, "CTRL write while frozen");
      $display("test reset done");
   endtask

   task automatic t_train();
      reg_wr(ADDR_CTRL, 32'h1);
      #1 chk("CDR_REF_SEL frl", 32'h1, 32'(cdr_sel));
      src_i.send_restart(3);
      set_lock(4'hF, 20);
      chk("PATTERN_CODE short restart", 32'(PATTERN_REQUEST), 32'(pcode));
      src_i.send_restart(4);
      set_lock(4'h7, 20);
      chk("TRAIN_PASSED lane3 unlocked", 32'h0, 32'(passed));
      reg_rd(ADDR_STATUS, 32'h72, "STATUS lock wait");
      set_lock(4'hF, 3);
      set_lock(4'h7, 2);
      set_lock(4'hF, 20);
      chk("PATTERN_CODE lock lost", 32'(PATTERN_REQUEST), 32'(pcode));
      src_i.send_restart(4);
      set_lock(4'hF, 20);
      chk("PATTERN_CODE passed", 32'(PATTERN_PASSED), 32'(pcode));
      chk("TRAIN_PASSED", 32'h1, 32'(passed));
      reg_rd(ADDR_STATUS, 32'hF9, "STATUS passed");
      reg_wr(ADDR_CTRL, 32'h9);
      repeat (3) @(posedge clock);
      chk("PATTERN_CODE retrain", 32'(PATTERN_REQUEST), 32'(pcode));
      reg_wr(ADDR_CTRL, 32'h0);
      #1 chk("CDR_REF_SEL tmds", 32'h0, 32'(cdr_sel));
      src_i.send_restart(4);
      set_lock(4'h7, 20);
      chk("TRAIN_PASSED tmds", 32'h1, 32'(passed));
      $display("test training done");
   endtask

   task automatic t_pace(input logic [31:0] ctrl, input realtime half, input int lim,
                         input int lo, input int hi, input string what);
      reg_wr(ADDR_CTRL, ctrl);
      vid_half = half;
      repeat (32) @(posedge clock);
      beats = 0;
      nvalid = 0;
      run = 0;
      max_run = 0;
      mon_on = 1'b1;
      for (int k = 0; k < 2000 && beats < 20; k++)
         @(posedge clock);
      mon_on = 1'b0;
      chk({what, " longest valid run"}, 32'h1, 32'(max_run <= lim));
      chk({what, " valid count"}, 32'h1, 32'(nvalid >= lo && nvalid <= hi));
      $display("test %s done", what);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      t_reset();
      frame_on <= 1'b1;
      t_train();
      // Video period set per mode and depth.
      t_pace(32'h2, 250.0, 20, 20, 20, "tmds10");
      t_pace(32'h6, 400.0, 20, 20, 20, "tmds16");
      t_pace(32'h3, 160.0, int'(CAD_NUM_10), 12, 16, "frl10");
      t_pace(32'h5, 400.0 / 3, int'(CAD_NUM_12), 10, 14, "frl12");
      t_pace(32'h7, 100.0, int'(CAD_NUM_16), 8, 10, "frl16");
      t_pace(32'h3, 100.0, int'(CAD_NUM_10), 7, 10, "frl10fast");
      end_of_test();
   end
endmodule // tb_top
